// ---- logic/kwu_pkg.sv ----
// constants for the keypad wake unit: register map, field positions, resets
// assumes a classic wishbone slave with 32-bit data and byte addresses
package kwu_pkg;
    localparam int          KWU_NUM_PINS      = 6;
    localparam int          KWU_ADDR_W        = 4;
    localparam int          KWU_DATA_W        = 32;
    // register byte offsets
    localparam logic [3:0]  KWU_OFF_STATUS    = 4'h0;
    localparam logic [3:0]  KWU_OFF_ENABLE    = 4'h4;
    localparam logic [3:0]  KWU_OFF_POLARITY  = 4'h8;
    localparam logic [3:0]  KWU_OFF_DIR       = 4'hc;
    // key_status_control field positions
    localparam int          KWU_BIT_MODE      = 0;
    localparam int          KWU_BIT_MASK      = 1;
    localparam int          KWU_BIT_ACK       = 2;
    localparam int          KWU_BIT_FLAG      = 3;
    // reset values
    localparam logic        KWU_RST_MODE      = 1'b0;
    localparam logic        KWU_RST_MASK      = 1'b0;
    localparam logic [5:0]  KWU_RST_ENABLE    = 6'h00;
    localparam logic [5:0]  KWU_RST_POLARITY  = 6'h00;
    localparam logic [5:0]  KWU_RST_DIR       = 6'h00;
    // unmapped reads return this value
    localparam logic [31:0] KWU_UNMAPPED_DATA = 32'h0000_0000;
endpackage

// ---- logic/kwu_pin_sync.sv ----
// one keypad pin: two-flop synchroniser, polarity fold and edge detect
// assumes the pin is already synchronous per house rule but still resamples
`timescale 1ns/1ps
module kwu_pin_sync (
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    input  wire logic pin_in,
    input  wire logic polarity_in,
    output logic      level_out,
    output logic      asserted_out,
    output logic      edge_out
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;

    // synchroniser; first stage feeds only the second
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // active level follows polarity: 1 high/rising, 0 low/falling
    assign level_out    = sync2_reg;
    assign asserted_out = sync2_reg ~^ polarity_in;
    // edge toward the active level
    assign edge_out     = (sync2_reg ~^ polarity_in) & (prev_reg ^ polarity_in);
endmodule

// ---- logic/kwu_bus_slave.sv ----
// classic wishbone slave decode: one-cycle ack, strobes for write and read
// assumes the master holds the request until it sees ack
`timescale 1ns/1ps
module kwu_bus_slave (
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    input  wire logic wb_cyc_in,
    input  wire logic wb_stb_in,
    input  wire logic wb_we_in,
    output logic      wb_ack_out,
    output logic      wr_stb_out,
    output logic      rd_stb_out
);
    logic ack_reg;

    // ack one cycle after the request; dropped next cycle so it never repeats
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_cyc_in & wb_stb_in & ~ack_reg;
        end
    end

    assign wb_ack_out = ack_reg;
    // request is accepted in the cycle before ack rises
    assign wr_stb_out = wb_cyc_in & wb_stb_in & ~ack_reg & wb_we_in;
    assign rd_stb_out = wb_cyc_in & wb_stb_in & ~ack_reg & ~wb_we_in;
endmodule

// ---- logic/kwu_keypad_wake_unit.sv ----
// keypad wake unit: per-pin enable and polarity, shared request latch,
// edge or edge-and-level sensing, mask, acknowledge and wake output
// assumes one 250 MHz clock, synchronous active-high reset, wishbone access
`timescale 1ns/1ps

// Behaviour
// R01: each keypad pin has its own enable bit, independent of others.
// R02: each pin's polarity bit picks rising/high or falling/low detection.
// R03: one sense bit selects edge-only or edge-and-level for all pins.
// R04: enabled pin gets pullup when active low, pulldown when active high.
// R05: latch sets when any enabled pin asserts per polarity and mode.
// R06: edge-only: an edge is ignored while another enabled pin is asserted.
// R07: edge-and-level: request stays while any enabled pin is asserted.
// R08: edge-and-level: clear needs all pins idle and an ack, any order.
// R09: a vector fetch acknowledges and clears the latch.
// R10: writing 1 to the ack bit clears the latch like a vector fetch.
// R11: edges after a software ack still latch new requests.
// R12: request reaches the cpu only while the mask bit is clear.
// R13: unmasked latched request makes the cpu take the keypad vector.
// R14: reset clears the latch and the sense bit even if pins stay active.
// R15: edge-only: ack clears the latch at once.
// R16: pending flag is readable regardless of the mask.
// R17: enable forces the pin to input; level readable only when direction 0.
// R18: software masks, sets polarity, enables, acks, then unmasks; the bench acks and unmasks in one write.
// R19: software waits a load-dependent time before acking level pins.
// R20: unit runs in wait and stop; unmasked request wakes the cpu.
// R21: polarity 1 is high/rising, polarity 0 is low/falling.
// R22: the ack bit is write-only and reads zero.
// R23: there are six per-pin enable bits.
// R24: pins are synchronised and edges found from successive samples.
module kwu_keypad_wake_unit
    import kwu_pkg::*;
#(
    parameter int NUM_PINS = kwu_pkg::KWU_NUM_PINS
) (
    input  wire logic                          sys_clk_in,
    input  wire logic                          rst_in,
    input  wire logic                          wb_cyc_in,
    input  wire logic                          wb_stb_in,
    input  wire logic                          wb_we_in,
    input  wire logic [kwu_pkg::KWU_ADDR_W-1:0] wb_adr_in,
    input  wire logic [3:0]                    wb_sel_in,
    input  wire logic [kwu_pkg::KWU_DATA_W-1:0] wb_dat_in,
    output logic      [kwu_pkg::KWU_DATA_W-1:0] wb_dat_out,
    output logic                               wb_ack_out,
    input  wire logic [NUM_PINS-1:0]           key_pin_in,
    input  wire logic                          vector_fetch_in,
    output logic      [NUM_PINS-1:0]           pin_pullup_out,
    output logic      [NUM_PINS-1:0]           pin_pulldown_out,
    output logic      [NUM_PINS-1:0]           pin_dir_out,
    output logic                               irq_request_out,
    output logic                               wake_out
);
    import kwu_pkg::*;

    logic [NUM_PINS-1:0] pin_enable_reg;
    logic [NUM_PINS-1:0] pin_polarity_reg;
    logic [NUM_PINS-1:0] pin_dir_reg;
    logic                level_sense_sel_reg;
    logic                request_mask_reg;
    logic                latch_reg;
    logic                ack_seen_reg;
    logic [NUM_PINS-1:0] pin_level;
    logic [NUM_PINS-1:0] pin_asserted;
    logic [NUM_PINS-1:0] pin_edge;
    logic [NUM_PINS-1:0] en_asserted;
    logic [NUM_PINS-1:0] en_edge;
    logic                wr_stb;
    logic                rd_stb;
    logic                any_asserted;
    logic                edge_hit;
    logic                sw_ack;
    logic                ack_evt;
    logic                pending_flag;
    logic                latch_next;
    logic                ack_seen_next;
    logic [KWU_DATA_W-1:0] rd_data;
    logic [KWU_DATA_W-1:0] dat_reg;

    // per-pin synchroniser and edge detector
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            kwu_pin_sync u_sync (
                .sys_clk_in   (sys_clk_in),
                .rst_in       (rst_in),
                .pin_in       (key_pin_in[g]),
                .polarity_in  (pin_polarity_reg[g]),
                .level_out    (pin_level[g]),
                .asserted_out (pin_asserted[g]),
                .edge_out     (pin_edge[g])
            ); // R24 R21 R02
        end
    endgenerate

    kwu_bus_slave u_bus (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .wb_cyc_in  (wb_cyc_in),
        .wb_stb_in  (wb_stb_in),
        .wb_we_in   (wb_we_in),
        .wb_ack_out (wb_ack_out),
        .wr_stb_out (wr_stb),
        .rd_stb_out (rd_stb)
    );

    // gate every source by its own enable
    assign en_asserted  = pin_asserted & pin_enable_reg; // R01
    assign en_edge      = pin_edge & pin_enable_reg; // R01
    assign any_asserted = |en_asserted;

    // an edge counts only if no other enabled pin already sits asserted
    always_comb begin
        edge_hit = 1'b0;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (en_edge[i] && ((en_asserted & ~(NUM_PINS'(1) << i)) == '0)) begin
                edge_hit = 1'b1; // R06
            end
        end
    end

    // software ack: write with lane 0 and ack bit set
    assign sw_ack  = wr_stb && wb_adr_in == KWU_OFF_STATUS && wb_sel_in[0]
                     && wb_dat_in[KWU_BIT_ACK]; // R10
    assign ack_evt = sw_ack | vector_fetch_in; // R09

    // latch update; a new edge wins over a simultaneous ack
    always_comb begin
        latch_next    = latch_reg;
        ack_seen_next = ack_seen_reg;
        if (!level_sense_sel_reg) begin
            ack_seen_next = 1'b0;
            if (ack_evt) begin
                latch_next = 1'b0; // R15
            end
        end else begin
            if (ack_evt) begin
                ack_seen_next = 1'b1;
            end
            if ((ack_evt || ack_seen_reg) && !any_asserted) begin
                latch_next    = 1'b0; // R08
                ack_seen_next = 1'b0;
            end
            if (any_asserted) begin
                latch_next = 1'b1; // R07
            end
        end
        if (edge_hit) begin
            latch_next    = 1'b1; // R05 R11
            ack_seen_next = 1'b0;
        end
    end

    // shared request latch, cleared by reset whatever the pins do
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            latch_reg    <= 1'b0; // R14
            ack_seen_reg <= 1'b0;
        end else begin
            latch_reg    <= latch_next;
            ack_seen_reg <= ack_seen_next;
        end
    end

    assign pending_flag = latch_reg; // R16

    // key_status_control write fields
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            level_sense_sel_reg <= KWU_RST_MODE; // R14
            request_mask_reg    <= KWU_RST_MASK;
        end else if (wr_stb && wb_adr_in == KWU_OFF_STATUS && wb_sel_in[0]) begin
            level_sense_sel_reg <= wb_dat_in[KWU_BIT_MODE]; // R03
            request_mask_reg    <= wb_dat_in[KWU_BIT_MASK];
        end
    end

    // pin enable, polarity and direction registers
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pin_enable_reg   <= KWU_RST_ENABLE[NUM_PINS-1:0];
            pin_polarity_reg <= KWU_RST_POLARITY[NUM_PINS-1:0];
            pin_dir_reg      <= KWU_RST_DIR[NUM_PINS-1:0];
        end else if (wr_stb && wb_sel_in[0]) begin
            unique case (wb_adr_in)
                KWU_OFF_ENABLE:   pin_enable_reg   <= wb_dat_in[NUM_PINS-1:0]; // R23
                KWU_OFF_POLARITY: pin_polarity_reg <= wb_dat_in[NUM_PINS-1:0];
                KWU_OFF_DIR:      pin_dir_reg      <= wb_dat_in[NUM_PINS-1:0];
                default: ;
            endcase
        end
    end

    // read mux; ack bit always reads zero, unmapped reads zero
    always_comb begin
        rd_data = KWU_UNMAPPED_DATA;
        unique case (wb_adr_in)
            KWU_OFF_STATUS: begin
                rd_data[KWU_BIT_MODE] = level_sense_sel_reg;
                rd_data[KWU_BIT_MASK] = request_mask_reg;
                rd_data[KWU_BIT_ACK]  = 1'b0; // R22
                rd_data[KWU_BIT_FLAG] = pending_flag; // R16
            end
            KWU_OFF_ENABLE:   rd_data[NUM_PINS-1:0] = pin_enable_reg;
            KWU_OFF_POLARITY: rd_data[NUM_PINS-1:0] = pin_polarity_reg;
            // pin level visible only on bits whose direction is input
            KWU_OFF_DIR: rd_data[NUM_PINS-1:0] = pin_level & ~pin_dir_reg; // R17
            default: ;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            dat_reg <= KWU_UNMAPPED_DATA;
        end else if (rd_stb) begin
            dat_reg <= rd_data;
        end
    end
    assign wb_dat_out = dat_reg;

    // pad control and cpu request; registered so outputs come from flops
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pin_pullup_out   <= '0;
            pin_pulldown_out <= '0;
            pin_dir_out      <= '0;
            irq_request_out  <= 1'b0;
            wake_out         <= 1'b0;
        end else begin
            pin_pullup_out   <= pin_enable_reg & ~pin_polarity_reg; // R04
            pin_pulldown_out <= pin_enable_reg & pin_polarity_reg; // R04
            pin_dir_out      <= pin_dir_reg & ~pin_enable_reg; // R17
            irq_request_out  <= latch_next & ~request_mask_reg; // R12 R13
            // no gated clock here, so wait and stop see the same request
            wake_out         <= latch_next & ~request_mask_reg; // R20
        end
    end

    // assertions
    sequence s_ack_idle;
        ack_evt && !any_asserted && !edge_hit;
    endsequence

    mask_gate_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        request_mask_reg |=> !irq_request_out) // R12
        else $error("request passed while masked");
    edge_only_clear_a: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        (!level_sense_sel_reg && ack_evt && !edge_hit) |=> !latch_reg) // R15
        else $error("edge mode ack did not clear latch");
    level_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (level_sense_sel_reg && any_asserted) |=> latch_reg) // R07
        else $error("level request dropped while asserted");
    level_clear_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (s_ack_idle and level_sense_sel_reg) |=> !latch_reg) // R08
        else $error("level latch not cleared after ack and idle");
    edge_set_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        edge_hit |=> latch_reg ##1 (irq_request_out || request_mask_reg)) // R05
        else $error("edge did not latch");
    ack_reads_zero_a: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        (rd_stb && wb_adr_in == KWU_OFF_STATUS) |=> !wb_dat_out[KWU_BIT_ACK]) // R22
        else $error("ack bit read as one");
    reset_clear_a: assert property (@(posedge sys_clk_in)
        rst_in |=> !latch_reg && !level_sense_sel_reg) // R14
        else $error("reset left latch or mode set");
    pull_select_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ##1 (pin_pullup_out == ($past(pin_enable_reg) & ~$past(pin_polarity_reg)))) // R04
        else $error("pull device does not follow polarity");
    wake_match_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wake_out == irq_request_out) // R20
        else $error("wake differs from request");
endmodule

// ---- verif/kwu_key_model.sv ----
// behavioural keypad: six keys that the bench presses or lets go
// assumes the bench changes hold_in and press_in just after a clock edge
`timescale 1ns/1ps
module kwu_key_model (
    input  wire logic       sys_clk_in,
    input  wire logic [5:0] hold_in,
    input  wire logic [5:0] press_in,
    input  wire logic [5:0] pullup_in,
    input  wire logic [5:0] pulldown_in,
    output logic      [5:0] pin_out
);
    // a released key floats to its pull; with no pull it wanders,
    // so a stale level can never pass for a driven one
    always_ff @(posedge sys_clk_in) begin
        for (int i = 0; i < 6; i++) begin
            if (hold_in[i]) begin
                pin_out[i] <= press_in[i];
            end else if (pullup_in[i]) begin
                pin_out[i] <= 1'b1;
            end else if (pulldown_in[i]) begin
                pin_out[i] <= 1'b0;
            end else begin
                pin_out[i] <= ~pin_out[i];
            end
        end
    end
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the keypad wake unit over classic wishbone
// assumes the key model above and the package constants
`timescale 1ns/1ps
module testbench;
    import kwu_pkg::*;
    logic        sys_clk_in, rst_in, cyc, stb, we, vfetch, ack, irq, wake;
    logic [3:0]  adr;
    logic [31:0] wdat, rdat, rd, lfsr, r;
    logic [5:0]  pins, pu, pd, dir, hold, press;
    int          num_errors, checked;

    kwu_keypad_wake_unit uut (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(4'h1), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .key_pin_in(pins), .vector_fetch_in(vfetch),
        .pin_pullup_out(pu), .pin_pulldown_out(pd), .pin_dir_out(dir),
        .irq_request_out(irq), .wake_out(wake));
    kwu_key_model keys (
        .sys_clk_in(sys_clk_in), .hold_in(hold), .press_in(press),
        .pullup_in(pu), .pulldown_in(pd), .pin_out(pins));

    // free-running 250 MHz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    function automatic logic [31:0] next_rand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; ack is sampled at the edge, data taken there
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge sys_clk_in);
    endtask

    task automatic key(input logic [5:0] h);
        @(posedge sys_clk_in);
        hold <= h;
    endtask

    // pin changes take a few edges through the synchroniser
    task automatic irq_is(input logic e);
        repeat (8) @(posedge sys_clk_in);
        chk({30'h0, wake, irq}, {30'h0, e, e});
    endtask

    task automatic fetch();
        @(posedge sys_clk_in);
        vfetch <= 1'b1;
        @(posedge sys_clk_in);
        vfetch <= 1'b0;
    endtask

    // masked setup, settle, then acknowledge and unmask in one write
    task automatic cfg(input logic m, input logic [5:0] en, p);
        bus(1, KWU_OFF_STATUS, {30'h0, 1'b1, m});
        bus(1, KWU_OFF_POLARITY, {26'h0, p});
        bus(1, KWU_OFF_ENABLE, {26'h0, en});
        press <= p;
        repeat (8) @(posedge sys_clk_in);
        bus(1, KWU_OFF_STATUS, {29'h0, 2'b10, m});
    endtask

    task automatic test_done();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // hang guard well beyond the few hundred cycles needed
    initial begin
        #80000;
        num_errors++;
        test_done();
    end

    initial begin
        {cyc, stb, we, vfetch, adr, wdat, hold, press} = '0;
        num_errors = 0;
        checked = 0;
        lfsr = 32'hdb32;
        rst_in = 1'b1;
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        bus(0, KWU_OFF_STATUS, 0);
        chk(rd, 32'h0);
        bus(0, KWU_OFF_ENABLE, 0);
        chk(rd, {26'h0, KWU_RST_ENABLE});
        bus(1, 4'h1, 32'hff);
        bus(0, 4'h1, 0);
        chk(rd, KWU_UNMAPPED_DATA);
        $display("test reset done");
        // random enables, polarities and directions
        repeat (6) begin
            r = next_rand();
            bus(1, KWU_OFF_POLARITY, {26'h0, r[11:6]});
            bus(1, KWU_OFF_ENABLE, {26'h0, r[5:0]});
            bus(1, KWU_OFF_DIR, {26'h0, r[17:12]});
            chk({26'h0, pu}, {26'h0, r[5:0] & ~r[11:6]});
            chk({26'h0, pd}, {26'h0, r[5:0] & r[11:6]});
            chk({26'h0, dir}, {26'h0, r[17:12] & ~r[5:0]});
            bus(0, KWU_OFF_ENABLE, 0);
            chk(rd, {26'h0, r[5:0]});
        end
        $display("test pins done");
        cfg(0, 6'h03, 6'h01);
        key(6'h01);
        irq_is(1);
        bus(0, KWU_OFF_STATUS, 0);
        chk(rd, 32'h8);
        bus(1, KWU_OFF_STATUS, 32'h4);
        chk({31'h0, irq}, 32'h0);
        key(6'h00);
        irq_is(0);
        key(6'h02);
        irq_is(1);
        bus(1, KWU_OFF_STATUS, 32'h4);
        key(6'h03);
        irq_is(0);
        key(6'h00);
        bus(1, KWU_OFF_STATUS, 32'h4);
        key(6'h01);
        irq_is(1);
        fetch();
        irq_is(0);
        key(6'h00);
        $display("test edge done");
        cfg(1, 6'h01, 6'h01);
        key(6'h01);
        irq_is(1);
        fetch();
        irq_is(1);
        key(6'h00);
        irq_is(0);
        key(6'h01);
        key(6'h00);
        irq_is(1);
        bus(1, KWU_OFF_STATUS, 32'h5);
        irq_is(0);
        bus(1, KWU_OFF_STATUS, 32'h3);
        key(6'h01);
        irq_is(0);
        bus(0, KWU_OFF_STATUS, 0);
        chk(rd, 32'hb);
        bus(1, KWU_OFF_STATUS, 32'h1);
        irq_is(1);
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        irq_is(0);
        bus(0, KWU_OFF_STATUS, 0);
        chk(rd, 32'h0);
        $display("test level done");
        test_done();
    end
endmodule
